/* bench/eif_partner.sv */
// partner: external pin sources and cpu vectoring for both interrupts
module eif_partner #(
	parameter int ACK_WAIT = 3
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic lvl0,
	input wire logic lvl1,
	input wire logic ack_en,
	input wire logic irq_req0,
	input wire logic irq_req1,
	output logic ext_irq0_input,
	output logic ext_irq1_input,
	output logic vector_ack0,
	output logic vector_ack1
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt0;
	int cnt1;
	assign ext_irq0_input = lvl0;
	assign ext_irq1_input = lvl1;
	initial vector_ack0 = 1'b0;
	initial vector_ack1 = 1'b0;
	// -------------------------------------------------------
	// vectoring: one-cycle acknowledge after a service delay
	// -------------------------------------------------------
	always @(posedge clk_sys) begin
		if (rst || !ack_en || !irq_req0 || vector_ack0) begin
			cnt0 <= 0;
			vector_ack0 <= 1'b0;
		end else if (cnt0 == ACK_WAIT) begin
			vector_ack0 <= 1'b1;
		end else begin
			cnt0 <= cnt0 + 1;
		end
	end
	always @(posedge clk_sys) begin
		if (rst || !ack_en || !irq_req1 || vector_ack1) begin
			cnt1 <= 0;
			vector_ack1 <= 1'b0;
		end else if (cnt1 == ACK_WAIT) begin
			vector_ack1 <= 1'b1;
		end else begin
			cnt1 <= cnt1 + 1;
		end
	end
endmodule

/* bench/eif_top_bench.sv */
// bench: self-checking test of the external interrupt flag block
module eif_top_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import eif_pkg::*;
	logic clk_sys, rst, avs_read, avs_write, avs_waitrequest;
	logic irq_req0, irq_req1, lvl0, lvl1, ack_en;
	logic ext_irq0_input, ext_irq1_input, vector_ack0, vector_ack1;
	logic [EIF_ADDR_W-1:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic [3:0] avs_byteenable;
	int fail_count;
	int tests_run;
	eif_top eif_top_inst (.clk_sys(clk_sys), .rst(rst),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.ext_irq0_input(ext_irq0_input), .ext_irq1_input(ext_irq1_input),
		.vector_ack0(vector_ack0), .vector_ack1(vector_ack1),
		.irq_req0(irq_req0), .irq_req1(irq_req1));
	eif_partner #(.ACK_WAIT(3)) eif_partner_inst (.clk_sys(clk_sys),
		.rst(rst), .lvl0(lvl0), .lvl1(lvl1), .ack_en(ack_en),
		.irq_req0(irq_req0), .irq_req1(irq_req1),
		.ext_irq0_input(ext_irq0_input), .ext_irq1_input(ext_irq1_input),
		.vector_ack0(vector_ack0), .vector_ack1(vector_ack1));
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	// -------------------------------------------------------
	// shared tasks
	// -------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up;
		if (fail_count == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic bus(input logic wr, input logic [3:0] a,
		input logic [31:0] d, input logic [3:0] be);
		int n;
		n = 0;
		@(posedge clk_sys);
		avs_read <= !wr;
		avs_write <= wr;
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= be;
		@(posedge clk_sys);
		while (avs_waitrequest !== 1'b0 && n < 20) begin
			@(posedge clk_sys);
			n++;
		end
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (avs_waitrequest !== 1'b0) begin
			fail_count++;
			wrap_up();
		end
	endtask
	task automatic pin(input int w, input logic v);
		@(posedge clk_sys);
		if (w == 1) lvl1 <= v;
		else lvl0 <= v;
	endtask
	task automatic wait_req(input int w, input logic v);
		int n;
		n = 0;
		while ((w == 1 ? irq_req1 : irq_req0) !== v && n < 10) begin
			@(posedge clk_sys);
			n++;
		end
		check({31'h0, (w == 1 ? irq_req1 : irq_req0)}, {31'h0, v});
		if ((w == 1 ? irq_req1 : irq_req0) !== v) wrap_up();
	endtask
	// -------------------------------------------------------
	// scenarios
	// -------------------------------------------------------
	task automatic s_reset_map;
		bus(1'b0, EIF_OFF_CTRL, 32'h0, 4'hf);
		check(rd, EIF_RST_RDATA);
		bus(1'b0, EIF_OFF_PIN_CONFIG, 32'h0, 4'hf);
		check(rd, EIF_RST_RDATA);
		bus(1'b1, 4'hc, 32'hf, 4'hf);
		bus(1'b0, 4'hc, 32'h0, 4'hf);
		check(rd, 32'h0);
		bus(1'b0, EIF_OFF_CTRL, 32'h0, 4'hf);
		check(rd, 32'h0);
	endtask
	task automatic s_level0;
		pin(0, 1'b0);
		wait_req(0, 1'b1);
		bus(1'b0, EIF_OFF_CTRL, 32'h0, 4'hf);
		check(rd, 32'h2);
		ack_en <= 1'b1;
		bus(1'b1, EIF_OFF_CTRL, 32'h0, 4'hf);
		repeat (8) @(posedge clk_sys);
		check({31'h0, irq_req0}, 32'h1);
		ack_en <= 1'b0;
		pin(0, 1'b1);
		wait_req(0, 1'b0);
	endtask
	task automatic s_level1;
		bus(1'b1, EIF_OFF_PIN_CONFIG, 32'h2, 4'hf);
		wait_req(1, 1'b1);
		bus(1'b0, EIF_OFF_CTRL, 32'h0, 4'hf);
		check(rd, 32'h8);
		pin(1, 1'b0);
		wait_req(1, 1'b0);
		check({31'h0, irq_req0}, 32'h0);
	endtask
	task automatic s_edge;
		pin(0, 1'b0);
		bus(1'b1, EIF_OFF_PIN_CONFIG, 32'h3, 4'hf);
		bus(1'b1, EIF_OFF_CTRL, 32'h5, 4'hf);
		repeat (4) @(posedge clk_sys);
		check({30'h0, irq_req1, irq_req0}, 32'h0);
		pin(0, 1'b1);
		wait_req(0, 1'b1);
		pin(0, 1'b0);
		repeat (6) @(posedge clk_sys);
		check({31'h0, irq_req0}, 32'h1);
		bus(1'b0, EIF_OFF_CTRL, 32'h0, 4'hf);
		check(rd, 32'h7);
		bus(1'b1, EIF_OFF_CTRL, 32'h0, 4'h0);
		check({31'h0, irq_req0}, 32'h1);
		bus(1'b1, EIF_OFF_CTRL, 32'h5, 4'hf);
		wait_req(0, 1'b0);
		pin(1, 1'b1);
		wait_req(1, 1'b1);
		ack_en <= 1'b1;
		wait_req(1, 1'b0);
		ack_en <= 1'b0;
		repeat (6) @(posedge clk_sys);
		bus(1'b0, EIF_OFF_CTRL, 32'h0, 4'hf);
		check(rd, 32'h5);
		pin(1, 1'b0);
	endtask
	initial begin
		fail_count = 0;
		tests_run = 0;
		rst = 1'b1;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 4'h0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hf;
		lvl0 = 1'b1;
		lvl1 = 1'b1;
		ack_en = 1'b0;
		repeat (4) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		s_reset_map();
		s_level0();
		s_level1();
		s_edge();
		wrap_up();
	end
endmodule

/* logic/eif_detect.sv */
// module: pin synchroniser, polarity and edge detection for one input
module eif_detect (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic pin,
	input wire logic polarity,
	output logic active,
	output logic edge_seen
);
	import eif_pkg::*;

	logic sync1_q;
	logic sync2_q;
	logic prev_active_q;

	// ------------------------------------------------------------
	// two-stage synchroniser
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		// reset to the idle level of the reset polarity: no false flag
		if (rst) begin
			sync1_q <= !EIF_RST_POL;
			sync2_q <= !EIF_RST_POL;
		end else begin
			sync1_q <= pin;
			sync2_q <= sync1_q;
		end
	end

	// polarity picks the active level for both level and edge use
	assign active = polarity ? sync2_q : !sync2_q;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			prev_active_q <= 1'b0;
		end else begin
			prev_active_q <= active;
		end
	end

	// one-cycle pulse on the transition into the active level
	assign edge_seen = active && !prev_active_q;

endmodule

/* logic/eif_pkg.sv */
// package: constants for the external interrupt flag block
package eif_pkg;

	// ------------------------------------------------------------
	// register map (byte addresses, one aligned word each)
	// ------------------------------------------------------------
	localparam int EIF_ADDR_W = 4;
	localparam logic [3:0] EIF_OFF_CTRL = 4'h0;
	localparam logic [3:0] EIF_OFF_PIN_CONFIG = 4'h4;

	// ------------------------------------------------------------
	// control register fields
	// ------------------------------------------------------------
	localparam int EIF_BIT_IRQ0_TYPE = 0;
	localparam int EIF_BIT_IRQ0_PEND = 1;
	localparam int EIF_BIT_IRQ1_TYPE = 2;
	localparam int EIF_BIT_IRQ1_PEND = 3;

	// ------------------------------------------------------------
	// pin configuration register fields
	// ------------------------------------------------------------
	localparam int EIF_BIT_IRQ0_POL = 0;
	localparam int EIF_BIT_IRQ1_POL = 1;

	// ------------------------------------------------------------
	// reset values and encodings
	// ------------------------------------------------------------
	localparam logic EIF_RST_TYPE = 1'b0;
	localparam logic EIF_RST_POL = 1'b0;
	localparam logic EIF_RST_PEND = 1'b0;
	localparam logic EIF_TYPE_LEVEL = 1'b0;
	localparam logic EIF_TYPE_EDGE = 1'b1;
	localparam logic [31:0] EIF_RST_RDATA = 32'h0000_0000;
	localparam int EIF_NUM_IRQ = 2;

	// ------------------------------------------------------------
	// bus answer states
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		EIF_BUS_IDLE = 2'b01,
		EIF_BUS_ACK = 2'b10
	} eif_bus_e;

endpackage

/* logic/eif_top.sv */
// module: external interrupt flags with avalon-mm register access
//
// The Avalon-MM interface to the registers and the register addresses are this design's own decisions.
module eif_top (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [eif_pkg::EIF_ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic ext_irq0_input,
	input wire logic ext_irq1_input,
	input wire logic vector_ack0,
	input wire logic vector_ack1,
	output logic irq_req0,
	output logic irq_req1
);
	import eif_pkg::*;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic eif_hit(
		input logic [EIF_ADDR_W-1:0] addr,
		input logic [EIF_ADDR_W-1:0] off
	);
		eif_hit = (addr[EIF_ADDR_W-1:2] == off[EIF_ADDR_W-1:2]);
	endfunction

	function automatic int eif_type_bit(input int ch);
		eif_type_bit = (ch == 0) ? EIF_BIT_IRQ0_TYPE : EIF_BIT_IRQ1_TYPE;
	endfunction

	function automatic int eif_pend_bit(input int ch);
		eif_pend_bit = (ch == 0) ? EIF_BIT_IRQ0_PEND : EIF_BIT_IRQ1_PEND;
	endfunction

	function automatic int eif_pol_bit(input int ch);
		eif_pol_bit = (ch == 0) ? EIF_BIT_IRQ0_POL : EIF_BIT_IRQ1_POL;
	endfunction

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	eif_bus_e bus_state_q;
	logic waitrequest_q;
	logic [31:0] readdata_q;
	logic [31:0] readdata_d;
	logic wr_fire;
	logic rd_start;
	logic ctrl_wr;
	logic pin_wr;
	logic [EIF_NUM_IRQ-1:0] type_sel_q;
	logic [EIF_NUM_IRQ-1:0] polarity_q;
	logic [EIF_NUM_IRQ-1:0] pending_q;
	logic [EIF_NUM_IRQ-1:0] irq_q;
	logic [EIF_NUM_IRQ-1:0] pin_in;
	logic [EIF_NUM_IRQ-1:0] ack_in;
	logic [EIF_NUM_IRQ-1:0] active;
	logic [EIF_NUM_IRQ-1:0] edge_seen;
	logic [EIF_NUM_IRQ-1:0] sw_clr;

	assign pin_in = {ext_irq1_input, ext_irq0_input};
	assign ack_in = {vector_ack1, vector_ack0};

	// ------------------------------------------------------------
	// avalon-mm slave: one wait cycle, then a one-cycle answer
	// ------------------------------------------------------------
	assign rd_start = (avs_read || avs_write) && waitrequest_q;
	assign wr_fire = avs_write && !waitrequest_q;
	assign ctrl_wr = wr_fire && avs_byteenable[0]
		&& eif_hit(avs_address, EIF_OFF_CTRL);
	assign pin_wr = wr_fire && avs_byteenable[0]
		&& eif_hit(avs_address, EIF_OFF_PIN_CONFIG);

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			bus_state_q <= EIF_BUS_IDLE;
			waitrequest_q <= 1'b1;
		end else begin
			case (bus_state_q)
				EIF_BUS_IDLE: begin
					if (avs_read || avs_write) begin
						bus_state_q <= EIF_BUS_ACK;
						waitrequest_q <= 1'b0;
					end
				end
				EIF_BUS_ACK: begin
					bus_state_q <= EIF_BUS_IDLE;
					waitrequest_q <= 1'b1;
				end
				default: begin
					bus_state_q <= EIF_BUS_IDLE;
					waitrequest_q <= 1'b1;
				end
			endcase
		end
	end

	// read mux; unmapped addresses read as zero
	always_comb begin
		readdata_d = EIF_RST_RDATA;
		if (eif_hit(avs_address, EIF_OFF_CTRL)) begin
			readdata_d[EIF_BIT_IRQ0_TYPE] = type_sel_q[0];
			readdata_d[EIF_BIT_IRQ0_PEND] = pending_q[0];
			readdata_d[EIF_BIT_IRQ1_TYPE] = type_sel_q[1];
			readdata_d[EIF_BIT_IRQ1_PEND] = pending_q[1];
		end else if (eif_hit(avs_address, EIF_OFF_PIN_CONFIG)) begin
			readdata_d[EIF_BIT_IRQ0_POL] = polarity_q[0];
			readdata_d[EIF_BIT_IRQ1_POL] = polarity_q[1];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			readdata_q <= EIF_RST_RDATA;
		end else if (avs_read && rd_start) begin
			readdata_q <= readdata_d;
		end
	end

	assign avs_readdata = readdata_q;
	assign avs_waitrequest = waitrequest_q;

	// ------------------------------------------------------------
	// per-input configuration, detection and pending flags
	// ------------------------------------------------------------
	for (genvar i = 0; i < EIF_NUM_IRQ; i++) begin : g_irq

		eif_detect u_detect (
			.clk_sys(clk_sys),
			.rst(rst),
			.pin(pin_in[i]),
			.polarity(polarity_q[i]),
			.active(active[i]),
			.edge_seen(edge_seen[i])
		);

		// trigger type: 0 level, 1 edge
		always_ff @(posedge clk_sys) begin
			if (rst) begin
				type_sel_q[i] <= EIF_RST_TYPE;
			end else if (ctrl_wr) begin
				type_sel_q[i] <= avs_writedata[eif_type_bit(i)];
			end
		end

		// active level of the pin
		always_ff @(posedge clk_sys) begin
			if (rst) begin
				polarity_q[i] <= EIF_RST_POL;
			end else if (pin_wr) begin
				polarity_q[i] <= avs_writedata[eif_pol_bit(i)];
			end
		end

		// in edge mode, writing 0 to a pending bit clears it, writing 1 has no effect
		assign sw_clr[i] = ctrl_wr && !avs_writedata[eif_pend_bit(i)];

		// level mode tracks the pin; edge mode is sticky, set beats clear
		always_ff @(posedge clk_sys) begin
			if (rst) begin
				pending_q[i] <= EIF_RST_PEND;
			end else if (type_sel_q[i] == EIF_TYPE_LEVEL) begin
				pending_q[i] <= active[i];
			end else if (edge_seen[i]) begin
				pending_q[i] <= 1'b1;
			end else if (sw_clr[i] || ack_in[i]) begin
				pending_q[i] <= 1'b0;
			end
		end

		// request to the cpu, registered copy of the next flag value
		always_ff @(posedge clk_sys) begin
			if (rst) begin
				irq_q[i] <= EIF_RST_PEND;
			end else if (type_sel_q[i] == EIF_TYPE_LEVEL) begin
				irq_q[i] <= active[i];
			end else if (edge_seen[i]) begin
				irq_q[i] <= 1'b1;
			end else if (sw_clr[i] || ack_in[i]) begin
				irq_q[i] <= 1'b0;
			end
		end

		// --------------------------------------------------------
		// checks
		// --------------------------------------------------------
		property p_level_follow;
			@(posedge clk_sys) disable iff (rst)
			(type_sel_q[i] == EIF_TYPE_LEVEL)
				|=> (pending_q[i] == $past(active[i]));
		endproperty
		a_level_follow: assert property (p_level_follow)
			else $error("level flag does not follow input");

		property p_edge_set;
			@(posedge clk_sys) disable iff (rst)
			(type_sel_q[i] == EIF_TYPE_EDGE) && edge_seen[i]
				|=> pending_q[i];
		endproperty
		a_edge_set: assert property (p_edge_set)
			else $error("edge did not set pending flag");

		property p_ack_clear;
			@(posedge clk_sys) disable iff (rst)
			(type_sel_q[i] == EIF_TYPE_EDGE) && ack_in[i]
				&& !edge_seen[i] |=> !pending_q[i];
		endproperty
		a_ack_clear: assert property (p_ack_clear)
			else $error("vectoring did not clear edge flag");

		property p_sw_clear;
			@(posedge clk_sys) disable iff (rst)
			(type_sel_q[i] == EIF_TYPE_EDGE) && sw_clr[i]
				&& !edge_seen[i] |=> !pending_q[i];
		endproperty
		a_sw_clear: assert property (p_sw_clear)
			else $error("software write did not clear edge flag");

		property p_no_spurious;
			@(posedge clk_sys) disable iff (rst)
			(type_sel_q[i] == EIF_TYPE_EDGE) && !pending_q[i]
				&& !edge_seen[i] |=> !pending_q[i];
		endproperty
		a_no_spurious: assert property (p_no_spurious)
			else $error("edge flag set without an edge");

		property p_edge_once;
			@(posedge clk_sys) disable iff (rst)
			edge_seen[i] |=> !edge_seen[i];
		endproperty
		a_edge_once: assert property (p_edge_once)
			else $error("edge pulse lasted more than one cycle");

		property p_irq_match;
			@(posedge clk_sys) disable iff (rst)
			$rose(pending_q[i]) |-> irq_q[i] ##1 (irq_q[i] == pending_q[i]);
		endproperty
		a_irq_match: assert property (p_irq_match)
			else $error("request does not track pending flag");

		property p_pol_write;
			@(posedge clk_sys) disable iff (rst)
			pin_wr |=> (polarity_q[i]
				== $past(avs_writedata[eif_pol_bit(i)]));
		endproperty
		a_pol_write: assert property (p_pol_write)
			else $error("polarity bit not stored");

		property p_type_write;
			@(posedge clk_sys) disable iff (rst)
			ctrl_wr |=> (type_sel_q[i]
				== $past(avs_writedata[eif_type_bit(i)]));
		endproperty
		a_type_write: assert property (p_type_write)
			else $error("type select bit not stored");

		property p_level_no_clear;
			@(posedge clk_sys) disable iff (rst)
			(type_sel_q[i] == EIF_TYPE_LEVEL) && active[i]
				&& (sw_clr[i] || ack_in[i]) |=> pending_q[i];
		endproperty
		a_level_no_clear: assert property (p_level_no_clear)
			else $error("level flag cleared while input active");

		property p_pend_hold;
			@(posedge clk_sys) disable iff (rst)
			(type_sel_q[i] == EIF_TYPE_EDGE) && pending_q[i]
				&& !sw_clr[i] && !ack_in[i] |=> pending_q[i];
		endproperty
		a_pend_hold: assert property (p_pend_hold)
			else $error("edge flag dropped without a clear");

		property p_type_hold;
			@(posedge clk_sys) disable iff (rst)
			!ctrl_wr |=> $stable(type_sel_q[i]);
		endproperty
		a_type_hold: assert property (p_type_hold)
			else $error("type select changed without a write");

		property p_pol_hold;
			@(posedge clk_sys) disable iff (rst)
			!pin_wr |=> $stable(polarity_q[i]);
		endproperty
		a_pol_hold: assert property (p_pol_hold)
			else $error("polarity changed without a write");

		property p_edge_prev;
			@(posedge clk_sys) disable iff (rst)
			edge_seen[i] |-> !$past(active[i]);
		endproperty
		a_edge_prev: assert property (p_edge_prev)
			else $error("edge pulse without an inactive cycle before");
	end

	assign irq_req0 = irq_q[0];
	assign irq_req1 = irq_q[1];

	// ------------------------------------------------------------
	// bus checks
	// ------------------------------------------------------------
	property p_wait_drop;
		@(posedge clk_sys) disable iff (rst)
		(avs_read || avs_write) && waitrequest_q |=> !waitrequest_q;
	endproperty
	a_wait_drop: assert property (p_wait_drop)
		else $error("waitrequest not released one cycle after request");

	property p_wait_single;
		@(posedge clk_sys) disable iff (rst)
		!waitrequest_q |=> waitrequest_q;
	endproperty
	a_wait_single: assert property (p_wait_single)
		else $error("waitrequest low for more than one cycle");

	property p_read_ctrl;
		@(posedge clk_sys) disable iff (rst)
		avs_read && rd_start && eif_hit(avs_address, EIF_OFF_CTRL)
			|=> (avs_readdata[EIF_BIT_IRQ0_PEND] == $past(pending_q[0]))
			&& (avs_readdata[EIF_BIT_IRQ1_PEND] == $past(pending_q[1]));
	endproperty
	a_read_ctrl: assert property (p_read_ctrl)
		else $error("pending flags not returned on read");

	property p_read_pin;
		@(posedge clk_sys) disable iff (rst)
		avs_read && rd_start && eif_hit(avs_address, EIF_OFF_PIN_CONFIG)
			|=> (avs_readdata[EIF_BIT_IRQ0_POL] == $past(polarity_q[0]))
			&& (avs_readdata[EIF_BIT_IRQ1_POL] == $past(polarity_q[1]));
	endproperty
	a_read_pin: assert property (p_read_pin)
		else $error("polarity bits not returned on read");

	property p_read_type;
		@(posedge clk_sys) disable iff (rst)
		avs_read && rd_start && eif_hit(avs_address, EIF_OFF_CTRL)
			|=> (avs_readdata[EIF_BIT_IRQ0_TYPE] == $past(type_sel_q[0]))
			&& (avs_readdata[EIF_BIT_IRQ1_TYPE] == $past(type_sel_q[1]));
	endproperty
	a_read_type: assert property (p_read_type)
		else $error("type select bits not returned on read");

endmodule
